// ### bench/ddc_host_model.sv
/*
 Host model for the synthesizer serial port: clock, chip select and data lines.
 Assumes the bench calls frame() between its own bus cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module ddc_host_model (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] sdio,
  input  wire logic  ramp_lvl
);
  logic       busy;
  logic [3:0] bits_q;
  logic [3:0] last_q;

  // Idle lines zero and one show the inverse of the last bits, line two the ramp level; line three stays low.
  assign sdio = busy ? bits_q : {1'b0, ramp_lvl, ~last_q[1:0]};

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    busy = 1'b0;
    bits_q = 4'h0;
    last_q = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////
  // Data change while the clock is low and are taken on its rise.
  task automatic tick();
    #7.5 sclk = 1'b1;
    #7.5 sclk = 1'b0;
  endtask

  // Sends junk bits, an optional resync edge, then the top bits of a word.
  task automatic frame(input logic [1:0] mode, input logic [31:0] w, input int nbits,
                       input int junk, input logic rs);
    int          step;
    logic [31:0] s;
    step = (mode == 2'h1) ? 2 : (mode == 2'h2) ? 4 : 1;
    s = w;
    busy = 1'b1;
    bits_q = 4'h6;
    repeat (3) tick();
    cs_n = 1'b0;
    repeat (junk) tick();
    if (rs) begin
      bits_q = 4'h8;
      tick();
    end
    for (int k = 0; k < nbits; k += step) begin
      bits_q = (step == 4) ? s[31:28] : (step == 2) ? {2'h0, s[31:30]} : {3'h0, s[31]};
      s = s << step;
      tick();
    end
    #7.5 cs_n = 1'b1;
    last_q = bits_q;
    busy = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### bench/test_dds_digital_control_pins.sv
/*
 Self-checking bench of the synthesizer pin control block.
 Assumes the rtl package, the design and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_dds_digital_control_pins;
  import ddc_pkg::*;

  typedef struct packed {
    logic [1:0]  mode;
    logic [31:0] word;
    logic [3:0]  pins;
    logic [13:0] exp;
  } ddc_row_type;

  ddc_axi_req_type   axi_req;
  ddc_axi_rsp_type   axi_rsp;
  ddc_synth_ctl_type synth_ctl;
  ddc_row_type       r;
  logic              clk, rst, sclk, cs_n, io_update, master_reset;
  logic              clk_mode_sel, sync_in, sync_out, sync_clk, osc_en, ramp_lvl;
  logic [3:0]        sdio_i, sdio_o, sdio_oe, profile;
  logic [31:0]       active_word, prev, hi, pulses;
  int                num_errors = 0;
  int                compares = 0;
  ddc_row_type       rows [5] = '{
    '{2'h0, 32'h5a00_0100, 4'ha, 14'h1a00},
    '{2'h1, 32'h3c00_1200, 4'h5, 14'h2050},
    '{2'h2, 32'h0f0f_2300, 4'h3, 14'h3003},
    '{2'h3, 32'hc001_3100, 4'hb, 14'h1380},
    '{2'h0, 32'h1234_4300, 4'hf, 14'h0000}};

  ddc_ctl_pins DUT (
    .CLK(clk), .RST(rst), .AXI_REQ(axi_req), .AXI_RSP(axi_rsp),
    .SCLK(sclk), .CS_N(cs_n), .SDIO_I(sdio_i), .SDIO_O(sdio_o), .SDIO_OE(sdio_oe),
    .IO_UPDATE(io_update), .PROFILE_PINS(profile), .MASTER_RESET(master_reset),
    .CLK_MODE_SEL(clk_mode_sel), .SYNC_IN(sync_in), .SYNC_OUT(sync_out),
    .SYNC_CLK(sync_clk), .OSC_EN(osc_en), .ACTIVE_WORD(active_word), .SYNTH_CTL(synth_ctl));

  ddc_host_model host (.sclk(sclk), .cs_n(cs_n), .sdio(sdio_i), .ramp_lvl(ramp_lvl));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        axi_req.bready <= 1'b0;
        done = 1;
        chk32("bresp", 32'(er), 32'(axi_rsp.bresp));
      end
    end
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 0;
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) begin
        axi_req.rready <= 1'b0;
        done = 1;
        chk32("rdata", ed, axi_rsp.rdata);
        chk32("rresp", 32'(er), 32'(axi_rsp.rresp));
      end
    end
    @(posedge clk);
  endtask

  // Counts timing clock high cycles and alignment pulses over n cycles.
  task automatic count_clk(input int n);
    hi = '0;
    pulses = '0;
    repeat (n) begin
      @(negedge clk);
      hi = hi + 32'(sync_clk);
      pulses = pulses + 32'(sync_out);
    end
    @(posedge clk);
  endtask

  task end_of_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // The whole run takes about 400 cycles; the watchdog allows 30000 cycles.
  initial begin
    #3000000;
    num_errors++;
    end_of_test();
  end

  initial begin
    axi_req = '0;
    profile = 4'h0;
    io_update = 1'b0;
    master_reset = 1'b0;
    clk_mode_sel = 1'b0;
    sync_in = 1'b0;
    ramp_lvl = 1'b0;
    prev = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(8'h00, 32'h1, 2'h0);
    axi_rd(8'h08, 32'h0, 2'h0);
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      axi_wr(8'h00, {27'h0, 1'b0, r.mode, 2'h1}, 2'h0);
      host.frame(r.mode, r.word, 32, 0, 1'b0);
      repeat (8) @(posedge clk);
      axi_rd(8'h08, r.word, 2'h0);
      chk32("active_before", prev, active_word);
      io_update <= 1'b1;
      profile <= r.pins;
      repeat (8) @(posedge clk);
      io_update <= 1'b0;
      repeat (10) @(posedge clk);
      chk32("active_word", r.word, active_word);
      chk32("synth_ctl", 32'(r.exp), 32'(synth_ctl));
      prev = r.word;
    end
    host.frame(2'h0, 32'h7e57_0001, 16, 0, 1'b0);
    repeat (8) @(posedge clk);
    axi_rd(8'h08, prev, 2'h0);
    host.frame(2'h0, 32'h6b1d_e047, 32, 10, 1'b1);
    repeat (8) @(posedge clk);
    axi_rd(8'h08, 32'h6b1d_e047, 2'h0);
    profile <= 4'h9;
    clk_mode_sel <= 1'b1;
    sync_in <= 1'b1;
    repeat (8) @(posedge clk);
    axi_rd(8'h0c, 32'h96, 2'h0);
    chk32("osc_en", 32'h1, 32'(osc_en));
    clk_mode_sel <= 1'b0;
    axi_wr(8'h00, 32'h3, 2'h0);
    repeat (4) @(posedge clk);
    count_clk(40);
    chk32("sync_clk_high", 32'd20, hi);
    chk32("sync_out_pulses", 32'd10, pulses);
    chk32("osc_off", 32'h0, 32'(osc_en));
    axi_wr(8'h00, 32'h2, 2'h0);
    repeat (4) @(posedge clk);
    count_clk(8);
    chk32("sync_clk_off", 32'd0, hi);
    chk32("sync_out_kept", 32'd2, pulses);
    master_reset <= 1'b1;
    repeat (6) @(posedge clk);
    master_reset <= 1'b0;
    repeat (4) @(posedge clk);
    axi_rd(8'h00, 32'h1, 2'h0);
    axi_rd(8'h08, 32'h0, 2'h0);
    chk32("active_reset", 32'h0, active_word);
    axi_rd(8'h10, 32'h0, 2'h2);
    axi_wr(8'h14, 32'h1, 2'h2);
    axi_wr(8'h04, 32'h1, 2'h0);
    axi_rd(8'h04, 32'h0, 2'h0);
    axi_wr(8'h00, 32'h11, 2'h0);
    ramp_lvl <= 1'b1;
    repeat (10) @(posedge clk);
    chk32("ramp_up", 32'hf, 32'(synth_ctl.ramp_up));
    ramp_lvl <= 1'b0;
    repeat (10) @(posedge clk);
    chk32("ramp_down", 32'h0, 32'(synth_ctl.ramp_up));
    chk32("sdio_oe", 32'h0, 32'(sdio_oe));
    chk32("sdio_o", 32'h0, 32'(sdio_o));
    end_of_test();
  end
endmodule

`default_nettype wire

// ### rtl/ddc_consts.svh
/*
 Constants of the synthesizer pin control block: register offsets,
 field positions, reset values and divider phases.
 Assumes inclusion by bare name from the rtl folder.
*/
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH

`define DDC_OFS_CTRL    8'h00
`define DDC_OFS_ACTIVE  8'h04
`define DDC_OFS_BUFFER  8'h08
`define DDC_OFS_STATUS  8'h0c

`define DDC_CTRL_RST    8'h01
`define DDC_WORD_RST    32'h0000_0000
`define DDC_BIT_SCK_EN  0
`define DDC_BIT_MASTER  1
`define DDC_MODE_HI     3
`define DDC_MODE_LO     2
`define DDC_BIT_RAMP    4

`define DDC_PPC_HI      14
`define DDC_PPC_LO      12
`define DDC_KIND_HI     9
`define DDC_KIND_LO     8

`define DDC_WORD_BITS   6'h20
`define DDC_SC_RISE     2'h1
`define DDC_SYNC_ALIGN  2'h1

`define DDC_RESP_OKAY   2'h0
`define DDC_RESP_SLVERR 2'h2

`endif

// ### rtl/ddc_ctl_pins.sv
/*
 Pin-level control of a four-channel synthesizer: serial write
 port, commit strobe, profile pins, quarter-rate timing clock,
 master reset, oscillator select and multi-device alignment.
 Assumes CLK is the system clock, SCLK and CS_N come from the host,
 and software reaches the registers over AXI4-Lite.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
// Contract
// RL1: Master reset pin returns all internal registers to their defaults; the code resets only ctrl_q, buffer_q and active_q.
// RL2: Commit strobe rising edge copies serial buffer into active register.
// RL3: Commit strobe is sampled at the timing clock; misses shift one period.
// RL4: Host holds the commit strobe for one full timing-clock period.
// RL5: Timing clock output runs at a quarter system rate, can be disabled.
// RL6: Profile pin use follows the field in bits 14 to 12 of function_reg_one.
// RL7: Profile pins select keying levels, run sweeps or ramp amplitude.
// RL8: Host meets setup and hold of profile pins to the timing clock.
// RL9: Device takes write bits on rising serial clock; host reads on falling.
// RL10: Chip select is active low; device ignores the port while high.
// RL11: Serial data line zero serves the serial port only.
// RL12: Data lines one to three serve the port or amplitude ramp trigger.
// RL13: In one-bit or two-bit mode line three is the resync input.
// RL14: Host never leaves line three floating in those modes.
// RL15: Oscillator select high enables the crystal oscillator, low bypasses it.
// RL16: Master drives its sync output; slaves take it on their sync input.

`timescale 1ns/1ps
`default_nettype none
`include "ddc_consts.svh"

////////////////////////////////////////////////////////////////////
// Two-flop synchroniser.

module ddc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////
// Top of the pin control block.

module ddc_ctl_pins (
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire ddc_pkg::ddc_axi_req_type   AXI_REQ,
  output var  ddc_pkg::ddc_axi_rsp_type   AXI_RSP,
  input  wire logic                       SCLK,
  input  wire logic                       CS_N,
  input  wire logic [3:0]                 SDIO_I,
  output logic      [3:0]                 SDIO_O,
  output logic      [3:0]                 SDIO_OE,
  input  wire logic                       IO_UPDATE,
  input  wire logic [3:0]                 PROFILE_PINS,
  input  wire logic                       MASTER_RESET,
  input  wire logic                       CLK_MODE_SEL,
  input  wire logic                       SYNC_IN,
  output logic                            SYNC_OUT,
  output logic                            SYNC_CLK,
  output logic                            OSC_EN,
  output logic      [31:0]                ACTIVE_WORD,
  output var  ddc_pkg::ddc_synth_ctl_type SYNTH_CTL
);
  import ddc_pkg::*;

  logic [9:0]        raw_a;
  logic [9:0]        syn_a;
  logic [3:0]        prof_s;
  logic              upd_s;
  logic              mrst_s;
  logic              osc_s;
  logic              sin_s;
  logic              ramp_s;
  logic              tog_s;
  logic [1:0]        mode_s;
  logic [5:0]        cnt_q;
  logic [5:0]        cnt_d;
  logic [31:0]       sh_q;
  logic [31:0]       sh_d;
  logic [31:0]       hold_q;
  logic              tog_q;
  logic              resync;
  logic              word_end;
  logic              tog_prev_q;
  logic              sin_prev_q;
  logic              sin_rise;
  logic [1:0]        div_q;
  logic              sc_edge;
  logic              sync_clk_q;
  logic              sync_out_q;
  logic              osc_q;
  logic [3:0]        prof_q;
  logic              upd_prev_q;
  logic              commit;
  logic [31:0]       buffer_q;
  logic [31:0]       active_q;
  logic [7:0]        ctrl_q;
  ddc_synth_ctl_type synth_d;
  ddc_synth_ctl_type synth_q;
  ddc_axi_rsp_type   rsp_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_fire;
  logic              wr_map;
  logic              rd_map;
  logic [31:0]       rd_data;
  logic [3:0]        sdio_oe_q;

  //////////////////////////////////////////////////////////////////
  // Crossings into the system clock and into the serial clock.

  assign raw_a = {tog_q, SDIO_I[2], SYNC_IN, CLK_MODE_SEL,
                  MASTER_RESET, IO_UPDATE, PROFILE_PINS};

  ddc_sync #(.W(10)) u_sync_sys (
    .clk (CLK),
    .rst (RST),
    .d   (raw_a),
    .q   (syn_a)
  );

  assign prof_s = syn_a[3:0];
  assign upd_s  = syn_a[4];
  assign mrst_s = syn_a[5];
  assign osc_s  = syn_a[6];
  assign sin_s  = syn_a[7];
  assign ramp_s = syn_a[8];
  assign tog_s  = syn_a[9];

  ddc_sync #(.W(2)) u_sync_ser (
    .clk (SCLK),
    .rst (RST),
    .d   (ctrl_q[`DDC_MODE_HI:`DDC_MODE_LO]),
    .q   (mode_s)
  );

  //////////////////////////////////////////////////////////////////
  // Serial write port on the serial clock.

  always_comb begin
    case (mode_s)
      2'(SER_TWO_BIT): begin
        sh_d  = {sh_q[29:0], SDIO_I[1:0]};
        cnt_d = cnt_q + 6'h02;
      end
      2'(SER_FOUR_BIT): begin
        sh_d  = {sh_q[27:0], SDIO_I};
        cnt_d = cnt_q + 6'h04;
      end
      default: begin
        sh_d  = {sh_q[30:0], SDIO_I[0]}; // see RL11
        cnt_d = cnt_q + 6'h01;
      end
    endcase
  end

  assign resync   = (mode_s != 2'(SER_FOUR_BIT)) && SDIO_I[3]; // see RL13
  assign word_end = cnt_d == `DDC_WORD_BITS;

  // The frame is held clear while chip select is high.
  always_ff @(posedge SCLK or posedge RST or posedge CS_N) begin
    if (RST || CS_N) begin // see RL10
      cnt_q <= 6'h00;
      sh_q  <= `DDC_WORD_RST;
    end else begin
      sh_q <= sh_d; // see RL9
      if (resync || word_end) begin
        cnt_q <= 6'h00;
      end else begin
        cnt_q <= cnt_d;
      end
    end
  end

  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      hold_q <= `DDC_WORD_RST;
      tog_q  <= 1'b0;
    end else if (!CS_N && !resync && word_end) begin // see RL10
      hold_q <= sh_d;
      tog_q  <= ~tog_q;
    end
  end

  // Read-back is not driven; the lines stay released.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sdio_oe_q <= 4'h0;
    end else begin
      sdio_oe_q <= 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Serial buffer and commit into the active register.

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog_prev_q <= 1'b0;
    end else begin
      tog_prev_q <= tog_s;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      buffer_q <= `DDC_WORD_RST;
    end else if (mrst_s) begin // see RL1
      buffer_q <= `DDC_WORD_RST;
    end else if (tog_s ^ tog_prev_q) begin
      buffer_q <= hold_q;
    end
  end

  // Strobe and profile pins are sampled at timing clock rises only.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prof_q     <= 4'h0;
      upd_prev_q <= 1'b0;
    end else if (sc_edge) begin // see RL3
      prof_q     <= prof_s;
      upd_prev_q <= upd_s;
    end
  end

  assign commit = sc_edge && upd_s && !upd_prev_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      active_q <= `DDC_WORD_RST;
    end else if (mrst_s) begin // see RL1
      active_q <= `DDC_WORD_RST;
    end else if (commit) begin // see RL2
      active_q <= buffer_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Timing clock divider and multi-device alignment.

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sin_prev_q <= 1'b0;
    end else begin
      sin_prev_q <= sin_s;
    end
  end

  assign sin_rise = sin_s && !sin_prev_q;
  assign sc_edge  = div_q == `DDC_SC_RISE;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q <= 2'h0;
    end else if (!ctrl_q[`DDC_BIT_MASTER] && sin_rise) begin // see RL16
      div_q <= `DDC_SYNC_ALIGN;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_clk_q <= 1'b0;
      sync_out_q <= 1'b0;
    end else begin
      sync_clk_q <= ctrl_q[`DDC_BIT_SCK_EN] && (^div_q); // see RL5
      sync_out_q <= ctrl_q[`DDC_BIT_MASTER] && sc_edge; // see RL16
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_s; // see RL15
    end
  end

  //////////////////////////////////////////////////////////////////
  // Profile pin decode.

  always_comb begin
    synth_d      = '0;
    synth_d.kind = ddc_key_kind_type'(active_q[`DDC_KIND_HI:`DDC_KIND_LO]);
    case (active_q[`DDC_PPC_HI:`DDC_PPC_LO]) // see RL6
      3'(PIN_KEY): begin
        synth_d.key_level = prof_q; // see RL7
      end
      3'(PIN_SWEEP): begin
        synth_d.sweep_run = prof_q;
      end
      3'(PIN_RAMP): begin
        synth_d.ramp_up = prof_q;
      end
      3'(PIN_MIXED): begin
        synth_d.key_level = {2'h0, prof_q[1:0]};
        synth_d.sweep_run = {prof_q[3:2], 2'h0};
      end
      default: begin
        synth_d.kind = MOD_NONE;
      end
    endcase
    if (ctrl_q[`DDC_BIT_RAMP] &&
        ctrl_q[`DDC_MODE_HI:`DDC_MODE_LO] != 2'(SER_FOUR_BIT)) begin
      synth_d.ramp_up = {4{ramp_s}}; // see RL12
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      synth_q <= '0;
    end else begin
      synth_q <= synth_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  assign wr_fire = aw_got_q && w_got_q && !rsp_q.bvalid;
  assign wr_map  = awaddr_q == `DDC_OFS_CTRL || awaddr_q == `DDC_OFS_ACTIVE ||
                   awaddr_q == `DDC_OFS_BUFFER || awaddr_q == `DDC_OFS_STATUS;

  always_comb begin
    rd_map  = 1'b1;
    rd_data = 32'h0000_0000;
    case (AXI_REQ.araddr)
      `DDC_OFS_CTRL: begin
        rd_data = {24'h00_0000, ctrl_q};
      end
      `DDC_OFS_ACTIVE: begin
        rd_data = active_q;
      end
      `DDC_OFS_BUFFER: begin
        rd_data = buffer_q;
      end
      `DDC_OFS_STATUS: begin
        rd_data = {24'h00_0000, prof_q, upd_prev_q, sin_s, osc_q, 1'b0};
      end
      default: begin
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rsp_q         <= '0;
      rsp_q.awready <= 1'b1;
      rsp_q.wready  <= 1'b1;
      rsp_q.arready <= 1'b1;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (AXI_REQ.awvalid && rsp_q.awready) begin
        awaddr_q      <= AXI_REQ.awaddr;
        aw_got_q      <= 1'b1;
        rsp_q.awready <= 1'b0;
      end
      if (AXI_REQ.wvalid && rsp_q.wready) begin
        wdata_q      <= AXI_REQ.wdata;
        wstrb_q      <= AXI_REQ.wstrb;
        w_got_q      <= 1'b1;
        rsp_q.wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp  <= wr_map ? `DDC_RESP_OKAY : `DDC_RESP_SLVERR;
      end
      if (rsp_q.bvalid && AXI_REQ.bready) begin
        rsp_q.bvalid  <= 1'b0;
        rsp_q.awready <= 1'b1;
        rsp_q.wready  <= 1'b1;
      end
      if (AXI_REQ.arvalid && rsp_q.arready) begin
        rsp_q.arready <= 1'b0;
        rsp_q.rvalid  <= 1'b1;
        rsp_q.rdata   <= rd_data;
        rsp_q.rresp   <= rd_map ? `DDC_RESP_OKAY : `DDC_RESP_SLVERR;
      end
      if (rsp_q.rvalid && AXI_REQ.rready) begin
        rsp_q.rvalid  <= 1'b0;
        rsp_q.arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= `DDC_CTRL_RST;
    end else if (mrst_s) begin // see RL1
      ctrl_q <= `DDC_CTRL_RST;
    end else if (wr_fire && awaddr_q == `DDC_OFS_CTRL && wstrb_q[0]) begin
      ctrl_q <= wdata_q[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////
  // Outputs.

  assign AXI_RSP     = rsp_q;
  assign SDIO_O      = sdio_oe_q;
  assign SDIO_OE     = sdio_oe_q;
  assign SYNC_OUT    = sync_out_q;
  assign SYNC_CLK    = sync_clk_q;
  assign OSC_EN      = osc_q;
  assign ACTIVE_WORD = active_q;
  assign SYNTH_CTL   = synth_q;

  //////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_commit;
    sc_edge && upd_s && !upd_prev_q && !mrst_s;
  endsequence

  sequence s_out_pulse;
    sync_out_q ##1 !sync_out_q;
  endsequence

  chk_master_reset_all: assert property (@(posedge CLK) disable iff (RST) // see RL1
    mrst_s |=> active_q == `DDC_WORD_RST && buffer_q == `DDC_WORD_RST &&
               ctrl_q == `DDC_CTRL_RST)
    else $error("master reset left a register set");

  chk_commit_copy: assert property (@(posedge CLK) disable iff (RST) // see RL2
    s_commit |=> active_q == $past(buffer_q))
    else $error("commit did not copy the buffer");

  chk_sample_hold: assert property (@(posedge CLK) disable iff (RST) // see RL3
    !sc_edge |=> $stable(upd_prev_q) && $stable(prof_q))
    else $error("strobe sampled off the timing clock rise");

  chk_clk_rise_phase: assert property (@(posedge CLK) disable iff (RST) // see RL5
    $rose(sync_clk_q) |-> $past(div_q) == `DDC_SC_RISE &&
                          $past(ctrl_q[`DDC_BIT_SCK_EN]))
    else $error("timing clock rose at a wrong phase");

  chk_clk_off: assert property (@(posedge CLK) disable iff (RST) // see RL5
    !ctrl_q[`DDC_BIT_SCK_EN] |=> !sync_clk_q)
    else $error("timing clock runs while disabled");

  chk_ppc_sweep: assert property (@(posedge CLK) disable iff (RST) // see RL7
    active_q[`DDC_PPC_HI:`DDC_PPC_LO] == 3'(PIN_SWEEP)
      |=> synth_q.sweep_run == $past(prof_q))
    else $error("sweep run does not follow profile pins");

  chk_ppc_reserved: assert property (@(posedge CLK) disable iff (RST) // see RL6
    active_q[`DDC_PPC_HI:`DDC_PPC_LO] > 3'(PIN_MIXED)
      |=> synth_q.key_level == 4'h0 && synth_q.sweep_run == 4'h0)
    else $error("reserved pin setting drives outputs");

  chk_ramp_trigger: assert property (@(posedge CLK) disable iff (RST) // see RL12
    ctrl_q[`DDC_BIT_RAMP] && ctrl_q[`DDC_MODE_HI:`DDC_MODE_LO] != 2'(SER_FOUR_BIT)
      |=> synth_q.ramp_up == {4{$past(ramp_s)}})
    else $error("ramp trigger not applied");

  chk_osc_follow: assert property (@(posedge CLK) disable iff (RST) // see RL15
    $rose(CLK_MODE_SEL) ##1 CLK_MODE_SEL[*3] |-> OSC_EN)
    else $error("oscillator enable missed the select pin");

  chk_sync_out_pulse: assert property (@(posedge CLK) disable iff (RST) // see RL16
    ctrl_q[`DDC_BIT_MASTER] && sc_edge |=> s_out_pulse)
    else $error("sync output pulse wrong");

  chk_slave_align: assert property (@(posedge CLK) disable iff (RST) // see RL16
    !ctrl_q[`DDC_BIT_MASTER] && sin_rise |=> div_q == `DDC_SYNC_ALIGN)
    else $error("slave divider not aligned");

  chk_cs_gate: assert property (@(posedge SCLK) disable iff (RST) // see RL10
    CS_N |=> $stable(tog_q) && $stable(hold_q))
    else $error("serial word taken with chip select high");

  chk_write_capture: assert property (@(posedge SCLK) disable iff (RST) // see RL9
    !CS_N && !resync && word_end |=> hold_q == $past(sh_d))
    else $error("serial word not captured");

  chk_resync_clear: assert property (@(posedge SCLK) disable iff (RST) // see RL13
    !CS_N && resync ##1 !CS_N |-> cnt_q == 6'h00)
    else $error("resync did not clear the bit count");

endmodule

`default_nettype wire

// ### rtl/ddc_pkg.sv
/*
 Types of the synthesizer pin control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ddc_pkg;

  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } ddc_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ddc_axi_rsp_type;

  typedef enum logic [1:0] {
    MOD_NONE,
    MOD_FREQUENCY_SHIFT_KEYING,
    MOD_PHASE_SHIFT_KEYING,
    MOD_AMPLITUDE_SHIFT_KEYING
  } ddc_key_kind_type;

  typedef enum logic [2:0] {
    PIN_KEY,
    PIN_SWEEP,
    PIN_RAMP,
    PIN_MIXED
  } ddc_ppc_type;

  typedef enum logic [1:0] {
    SER_ONE_BIT,
    SER_TWO_BIT,
    SER_FOUR_BIT
  } ddc_serial_mode_type;

  typedef struct packed {
    ddc_key_kind_type kind;
    logic [3:0]       key_level;
    logic [3:0]       sweep_run;
    logic [3:0]       ramp_up;
  } ddc_synth_ctl_type;

endpackage
